// >>> logic/watchdog_interval_timer.sv
// Added by the designer: the strobed register port.
`timescale 1ns/100ps


module watchdog_interval_timer #(
    parameter int PULSE_CYC = wdt_pkg::PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic interval_interrupt_request,
    output logic watchdog_overflow_output,
    output logic por_request,
    output logic manual_reset_request,
    output logic irq
);

    localparam int PCNT_W = $clog2(PULSE_CYC + 1);
    localparam logic [PCNT_W-1:0] PCNT_LOAD = PCNT_W'(PULSE_CYC - 1);
    localparam logic [PCNT_W-1:0] PCNT_ZERO = '0;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    logic iv_flag_r;
    logic mode_r;
    logic enable_r;
    logic [wdt_pkg::CKS_W-1:0] cks_r;
    logic [7:0] cnt_r;
    logic wd_flag_r;
    logic rst_en_r;
    logic rst_sel_r;
    logic iv_arm_r;
    logic wd_arm_r;
    logic [wdt_pkg::PRE_W-1:0] pre_r;
    logic [wdt_pkg::INT_W-1:0] int_stat_r;
    logic [wdt_pkg::INT_W-1:0] int_en_r;
    logic [15:0] rdata_r;
    logic irq_r;
    logic wd_out_r;
    logic por_r;
    logic mrst_r;
    wdt_pkg::pulse_t pstate_r;
    logic [PCNT_W-1:0] pcnt_r;

    // ------------------------------------------------------------
    // Prescaler decode
    // ------------------------------------------------------------

    // Returns the divide ratio minus one, so a tick fires when all masked bits are set.
    function automatic logic [wdt_pkg::PRE_W-1:0] div_mask(input logic [wdt_pkg::CKS_W-1:0] sel);
        logic [wdt_pkg::PRE_W-1:0] m;
        m = 13'h0001;
        case (sel)
            3'h0: m = 13'h0001;
            3'h1: m = 13'h003F;
            3'h2: m = 13'h007F;
            3'h3: m = 13'h00FF;
            3'h4: m = 13'h01FF;
            3'h5: m = 13'h03FF;
            3'h6: m = 13'h0FFF;
            3'h7: m = 13'h1FFF;
            default: m = 13'h0001;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    logic wr_tmr_ctrl;
    logic wr_count;
    logic wr_rst_ctrl;
    logic wr_int_clr;
    logic wr_int_en;
    logic rd_tmr_ctrl;
    logic rd_rst_ctrl;

    // Timer control, count and reset control writes are keyed by the upper byte so a stray word cannot touch the timer.
    assign wr_tmr_ctrl = wr && (addr == wdt_pkg::TMR_CTRL_WR_ADDR)
                         && (wdata[15:8] == wdt_pkg::TMR_CTRL_WR_KEY);
    assign wr_count = wr && (addr == wdt_pkg::COUNT_WR_ADDR)
                      && (wdata[15:8] == wdt_pkg::COUNT_WR_KEY);
    assign wr_rst_ctrl = wr && (addr == wdt_pkg::RST_CTRL_WR_ADDR)
                         && (wdata[15:8] == wdt_pkg::RST_CTRL_WR_KEY);
    assign wr_int_clr = wr && (addr == wdt_pkg::INT_CLR_ADDR);
    assign wr_int_en = wr && (addr == wdt_pkg::INT_EN_ADDR);
    assign rd_tmr_ctrl = rd && (addr == wdt_pkg::TMR_CTRL_RD_ADDR);
    assign rd_rst_ctrl = rd && (addr == wdt_pkg::RST_CTRL_RD_ADDR);

    // ------------------------------------------------------------
    // Tick and overflow events
    // ------------------------------------------------------------

    logic [wdt_pkg::PRE_W-1:0] mask;
    logic tick;
    logic wrap_evt;
    logic iv_evt;
    logic wd_evt;

    // The prescaler restarts with the enable, so the first tick comes one full period later.
    assign mask = div_mask(cks_r);
    assign tick = enable_r && ((pre_r & mask) == mask);
    assign wrap_evt = tick && (cnt_r == wdt_pkg::COUNT_MAX);
    assign iv_evt = wrap_evt && !mode_r;
    assign wd_evt = wrap_evt && mode_r;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------

    // Free count of system clocks while the timer runs.
    always_ff @(posedge ref_clk) begin
        if (rst || !enable_r || wd_evt) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------

    // Held at zero while disabled; a watchdog overflow reinitialises it.
    always_ff @(posedge ref_clk) begin
        if (rst || !enable_r) begin
            cnt_r <= wdt_pkg::COUNT_RST;
        end else if (wd_evt) begin
            cnt_r <= wdt_pkg::COUNT_RST;
        end else if (wr_count) begin
            cnt_r <= wdata[7:0];
        end else if (tick) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Timer control fields
    // ------------------------------------------------------------

    // A watchdog overflow puts the control fields back to reset values.
    always_ff @(posedge ref_clk) begin
        if (rst || wd_evt) begin
            mode_r <= 1'b0;
            enable_r <= 1'b0;
            cks_r <= wdt_pkg::CKS_RST;
        end else if (wr_tmr_ctrl) begin
            mode_r <= wdata[wdt_pkg::MODE_BIT];
            enable_r <= wdata[wdt_pkg::ENABLE_BIT];
            cks_r <= wdata[wdt_pkg::CKS_LSB +: wdt_pkg::CKS_W];
        end
    end

    // ------------------------------------------------------------
    // Interval overflow flag
    // ------------------------------------------------------------

    // A new overflow wins over a clearing write in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            iv_flag_r <= 1'b0;
        end else if (iv_evt) begin
            iv_flag_r <= 1'b1;
        end else if (wd_evt) begin
            iv_flag_r <= 1'b0;
        end else if (wr_tmr_ctrl && iv_arm_r && !wdata[wdt_pkg::IV_FLAG_BIT]) begin
            iv_flag_r <= 1'b0;
        end
    end

    // Arms the clear when software has seen the flag set.
    always_ff @(posedge ref_clk) begin
        if (rst || wd_evt) begin
            iv_arm_r <= 1'b0;
        end else if (wr_tmr_ctrl) begin
            iv_arm_r <= 1'b0;
        end else if (rd_tmr_ctrl && iv_flag_r) begin
            iv_arm_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset control and watchdog flag
    // ------------------------------------------------------------

    // Reset enable and select are plain software fields.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_en_r <= 1'b0;
            rst_sel_r <= 1'b0;
        end else if (wr_rst_ctrl) begin
            rst_en_r <= wdata[wdt_pkg::RST_EN_BIT];
            rst_sel_r <= wdata[wdt_pkg::RST_SEL_BIT];
        end
    end

    // The watchdog flag survives the timer's own reinitialisation.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wd_flag_r <= 1'b0;
        end else if (wd_evt) begin
            wd_flag_r <= 1'b1;
        end else if (wr_rst_ctrl && wd_arm_r && !wdata[wdt_pkg::WD_FLAG_BIT]) begin
            wd_flag_r <= 1'b0;
        end
    end

    // Arms the watchdog flag clear after a read that saw it set.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wd_arm_r <= 1'b0;
        end else if (wr_rst_ctrl) begin
            wd_arm_r <= 1'b0;
        end else if (rd_rst_ctrl && wd_flag_r) begin
            wd_arm_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Overflow pulse timer
    // ------------------------------------------------------------

    // Stretches the watchdog overflow into a pulse the outside can see.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pstate_r <= wdt_pkg::PULSE_IDLE;
            pcnt_r <= PCNT_ZERO;
        end else begin
            case (pstate_r)
                wdt_pkg::PULSE_IDLE: begin
                    if (wd_evt) begin
                        pstate_r <= wdt_pkg::PULSE_ACTIVE;
                        pcnt_r <= PCNT_LOAD;
                    end
                end
                wdt_pkg::PULSE_ACTIVE: begin
                    if (pcnt_r == PCNT_ZERO) begin
                        pstate_r <= wdt_pkg::PULSE_IDLE;
                    end else begin
                        pcnt_r <= pcnt_r - 1'b1;
                    end
                end
                default: begin
                    pstate_r <= wdt_pkg::PULSE_IDLE;
                    pcnt_r <= PCNT_ZERO;
                end
            endcase
        end
    end

    // Output and reset request rise together, so the reset never leads the output.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wd_out_r <= 1'b0;
            por_r <= 1'b0;
            mrst_r <= 1'b0;
        end else if (wd_evt) begin
            wd_out_r <= 1'b1;
            por_r <= rst_en_r && !rst_sel_r;
            mrst_r <= rst_en_r && rst_sel_r;
        end else if (pstate_r == wdt_pkg::PULSE_ACTIVE && pcnt_r == PCNT_ZERO) begin
            wd_out_r <= 1'b0;
            por_r <= 1'b0;
            mrst_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------

    logic [wdt_pkg::INT_W-1:0] int_evt;
    logic [wdt_pkg::INT_W-1:0] int_clr;

    assign int_evt = {wd_evt, iv_evt};
    assign int_clr = wr_int_clr ? wdata[wdt_pkg::INT_W-1:0] : wdt_pkg::INT_RST;

    // Sticky bits; an event in the clearing cycle is kept.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_stat_r <= wdt_pkg::INT_RST;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_evt;
        end
    end

    // Enable mask.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_en_r <= wdt_pkg::INT_RST;
        end else if (wr_int_en) begin
            int_en_r <= wdata[wdt_pkg::INT_W-1:0];
        end
    end

    // Registered so the line is glitch free, at the price of one cycle of lag.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_en_r);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    // Data stand only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge ref_clk) begin
        if (rst || !rd) begin
            rdata_r <= 16'h0000;
        end else begin
            case (addr)
                wdt_pkg::TMR_CTRL_RD_ADDR: begin
                    rdata_r <= {8'h00, iv_flag_r, mode_r, enable_r, 2'b11, cks_r} | {8'h00, wdt_pkg::TMR_CTRL_RSVD};
                end
                wdt_pkg::COUNT_RD_ADDR: begin
                    rdata_r <= {8'h00, cnt_r};
                end
                wdt_pkg::RST_CTRL_RD_ADDR: begin
                    rdata_r <= {8'h00, wd_flag_r, rst_en_r, rst_sel_r, wdt_pkg::RST_CTRL_RSVD[4:0]};
                end
                wdt_pkg::INT_STAT_ADDR: begin
                    rdata_r <= {14'h0000, int_stat_r};
                end
                wdt_pkg::INT_EN_ADDR: begin
                    rdata_r <= {14'h0000, int_en_r};
                end
                default: begin
                    rdata_r <= 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is a flip-flop; the interval request is the flag itself.
    assign rdata = rdata_r;
    assign interval_interrupt_request = iv_flag_r;
    assign watchdog_overflow_output = wd_out_r;
    assign por_request = por_r;
    assign manual_reset_request = mrst_r;
    assign irq = irq_r;

endmodule

// >>> logic/wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // Register addresses, byte addressed
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam logic [31:0] TMR_CTRL_RD_ADDR = 32'h05FFFFB8;
    localparam logic [31:0] TMR_CTRL_WR_ADDR = 32'h05FFFFB8;
    localparam logic [31:0] COUNT_RD_ADDR = 32'h05FFFFB9;
    localparam logic [31:0] COUNT_WR_ADDR = 32'h05FFFFB8;
    localparam logic [31:0] RST_CTRL_WR_ADDR = 32'h05FFFFBA;
    localparam logic [31:0] RST_CTRL_RD_ADDR = 32'h05FFFFBB;
    localparam logic [31:0] INT_STAT_ADDR = 32'h05FFFFA0;
    localparam logic [31:0] INT_CLR_ADDR = 32'h05FFFFA2;
    localparam logic [31:0] INT_EN_ADDR = 32'h05FFFFA4;

    // ------------------------------------------------------------
    // Write keys in the upper byte of a 16-bit write
    // ------------------------------------------------------------
    localparam logic [7:0] TMR_CTRL_WR_KEY = 8'hA5;
    localparam logic [7:0] COUNT_WR_KEY = 8'h5A;
    localparam logic [7:0] RST_CTRL_WR_KEY = 8'hA5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IV_FLAG_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int ENABLE_BIT = 5;
    localparam int CKS_LSB = 0;
    localparam int CKS_W = 3;
    localparam int WD_FLAG_BIT = 7;
    localparam int RST_EN_BIT = 6;
    localparam int RST_SEL_BIT = 5;
    localparam int INT_IV_BIT = 0;
    localparam int INT_WD_BIT = 1;
    localparam int INT_W = 2;

    // ------------------------------------------------------------
    // Reset values and reserved bits, which read as one
    // ------------------------------------------------------------
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [CKS_W-1:0] CKS_RST = 3'h0;
    localparam logic [7:0] TMR_CTRL_RSVD = 8'h18;
    localparam logic [7:0] RST_CTRL_RSVD = 8'h1F;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;

    // ------------------------------------------------------------
    // Prescaler and overflow pulse timing
    // ------------------------------------------------------------
    localparam int PRE_W = 13;
    localparam int PULSE_CYC = 128;

    typedef enum logic [0:0] {
        PULSE_IDLE = 1'b0,
        PULSE_ACTIVE = 1'b1
    } pulse_t;

endpackage

// >>> test/watchdog_interval_timer_chk.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Port checker for the watchdog and interval timer
// ------------------------------------------------------------
module watchdog_interval_timer_chk #(
    parameter int PULSE_CYC = wdt_pkg::PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic interval_interrupt_request,
    input wire logic watchdog_overflow_output,
    input wire logic por_request,
    input wire logic manual_reset_request,
    input wire logic irq
);
    logic [15:0] high_cnt_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Run length of the overflow pulse; a counter because the width is a parameter.
    always_ff @(posedge ref_clk) begin
        if (rst || !watchdog_overflow_output) begin
            high_cnt_r <= 16'h0000;
        end else begin
            high_cnt_r <= high_cnt_r + 16'h0001;
        end
    end

    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    rdata_upper_a: assert property (rd |=> rdata[15:8] == 8'h00)
        else $error("read answer upper byte not zero");
    unmapped_read_a: assert property (rd && addr[31:8] != 24'h05FFFF |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
    pulse_len_a: assert property ($fell(watchdog_overflow_output) |-> high_cnt_r == PULSE_CYC)
        else $error("overflow output pulse has wrong width");
    reset_window_a: assert property ((por_request || manual_reset_request) |->
        watchdog_overflow_output && !(por_request && manual_reset_request))
        else $error("reset request outside the overflow window");
    reset_start_a: assert property (($rose(por_request) || $rose(manual_reset_request)) |->
        $rose(watchdog_overflow_output))
        else $error("reset request not started with overflow output");
    flag_clear_a: assert property ($fell(interval_interrupt_request) |->
        $past(wr) || watchdog_overflow_output)
        else $error("interval flag dropped without a write");
    flag_rise_a: assert property ($rose(interval_interrupt_request) |-> !watchdog_overflow_output)
        else $error("interval flag set by a watchdog overflow");
    wd_clear_flag_a: assert property ($rose(watchdog_overflow_output) |-> !interval_interrupt_request)
        else $error("watchdog overflow left interval flag set");
endmodule

// >>> test/reset_logic_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Chip reset logic as the timer sees it
// ------------------------------------------------------------
module reset_logic_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic por_request,
    input wire logic manual_reset_request,
    output logic [7:0] por_cnt,
    output logic [7:0] man_cnt
);
    logic por_q_r;
    logic man_q_r;

    // Tally leading edges only; restarting the processor is left out so the bench runs on.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            por_q_r <= 1'b0;
            man_q_r <= 1'b0;
            por_cnt <= 8'h00;
            man_cnt <= 8'h00;
        end else begin
            por_q_r <= por_request;
            man_q_r <= manual_reset_request;
            if (por_request && !por_q_r) begin
                por_cnt <= por_cnt + 8'h01;
            end
            if (manual_reset_request && !man_q_r) begin
                man_cnt <= man_cnt + 8'h01;
            end
        end
    end
endmodule

// >>> test/watchdog_interval_timer_tb.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Self-checking bench for the watchdog and interval timer
// ------------------------------------------------------------
module watchdog_interval_timer_tb;
    localparam int PULSE_CYC = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] addr = 32'h00000000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic iv_req, wd_out, por_req, man_req, irq;
    logic [7:0] por_cnt, man_cnt;
    int mismatches = 0;
    int num_checks = 0;

    watchdog_interval_timer #(.PULSE_CYC(PULSE_CYC)) i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .interval_interrupt_request(iv_req),
        .watchdog_overflow_output(wd_out), .por_request(por_req), .manual_reset_request(man_req), .irq(irq));
    reset_logic_model i_rst_model (.ref_clk(ref_clk), .rst(rst), .por_request(por_req),
        .manual_reset_request(man_req), .por_cnt(por_cnt), .man_cnt(man_cnt));

    // Clock at 40 MHz.
    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus cycles are whole 16-bit writes and byte reads, one strobe cycle each.
    task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bus_rd(a, d);
        chk(d, exp);
    endtask

    task automatic wait_for(input logic wd, input int lim);
        for (int n = 0; n < lim && (wd ? wd_out : iv_req) !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
    endtask

    task automatic t_reset;
        rd_chk(wdt_pkg::TMR_CTRL_RD_ADDR, 16'h0018);
        rd_chk(wdt_pkg::COUNT_RD_ADDR, 16'h0000);
        rd_chk(wdt_pkg::RST_CTRL_RD_ADDR, 16'h001F);
        rd_chk(wdt_pkg::INT_STAT_ADDR, 16'h0000);
        rd_chk(wdt_pkg::INT_EN_ADDR, 16'h0000);
        rd_chk(32'h05FFFF00, 16'h0000);
        rd_chk(32'h05FFFEB8, 16'h0000);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'h0020);
        rd_chk(wdt_pkg::TMR_CTRL_RD_ADDR, 16'h0018);
        chk({11'h000, iv_req, wd_out, por_req, man_req, irq}, 16'h0000);
    endtask

    task automatic t_select;
        for (int s = 0; s < 8; s++) begin
            bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, {8'hA5, 5'b00100, s[2:0]});
            rd_chk(wdt_pkg::TMR_CTRL_RD_ADDR, {8'h00, 5'b00111, s[2:0]});
        end
        // Stop first so counter and prescaler start from zero for the timed count.
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA500);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA521);
        repeat (92) @(posedge ref_clk);
        rd_chk(wdt_pkg::COUNT_RD_ADDR, 16'h0001);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA500);
        rd_chk(wdt_pkg::COUNT_RD_ADDR, 16'h0000);
    endtask

    task automatic t_interval;
        bus_wr(wdt_pkg::INT_EN_ADDR, 16'h0001);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA520);
        repeat (490) @(negedge ref_clk);
        chk({15'h0000, iv_req}, 16'h0000);
        wait_for(1'b0, 60);
        chk({15'h0000, iv_req}, 16'h0001);
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, irq}, 16'h0001);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA520);
        rd_chk(wdt_pkg::TMR_CTRL_RD_ADDR, 16'h00B8);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA520);
        // The clear lands at the edge that ends the write; look once it has settled.
        @(negedge ref_clk);
        chk({15'h0000, iv_req}, 16'h0000);
        bus_wr(wdt_pkg::INT_CLR_ADDR, 16'h0001);
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, irq}, 16'h0000);
        bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA500);
    endtask

    // Three passes: no reset, power-on reset, manual reset; the interval enable masks the watchdog bit.
    task automatic t_watchdog;
        logic [15:0] d;
        logic [1:0] rs;
        logic [3:0] exp_o;
        for (int i = 0; i < 3; i++) begin
            rs = (i == 0) ? 2'b00 : ((i == 1) ? 2'b10 : 2'b11);
            exp_o = {2'b10, rs == 2'b10, rs == 2'b11};
            bus_wr(wdt_pkg::RST_CTRL_WR_ADDR, {8'hA5, 1'b0, rs, 5'h00});
            bus_wr(wdt_pkg::TMR_CTRL_WR_ADDR, 16'hA560);
            bus_wr(wdt_pkg::COUNT_WR_ADDR, 16'h5AF0);
            bus_rd(wdt_pkg::COUNT_RD_ADDR, d);
            chk(d, 16'h00F0);
            wait_for(1'b1, 80);
            chk({12'h000, wd_out, iv_req, por_req, man_req}, {12'h000, exp_o});
            repeat (PULSE_CYC) @(negedge ref_clk);
            chk({11'h000, wd_out, iv_req, por_req, man_req, irq}, 16'h0000);
            rd_chk(wdt_pkg::TMR_CTRL_RD_ADDR, 16'h0018);
            rd_chk(wdt_pkg::COUNT_RD_ADDR, 16'h0000);
            bus_wr(wdt_pkg::RST_CTRL_WR_ADDR, {8'hA5, 1'b0, rs, 5'h00});
            rd_chk(wdt_pkg::RST_CTRL_RD_ADDR, {8'h00, 1'b1, rs, 5'h1F});
            bus_wr(wdt_pkg::RST_CTRL_WR_ADDR, {8'hA5, 1'b0, rs, 5'h00});
            rd_chk(wdt_pkg::RST_CTRL_RD_ADDR, {8'h00, 1'b0, rs, 5'h1F});
        end
        rd_chk(wdt_pkg::INT_STAT_ADDR, 16'h0002);
        bus_wr(wdt_pkg::INT_EN_ADDR, 16'h0002);
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, irq}, 16'h0001);
        bus_wr(wdt_pkg::INT_CLR_ADDR, 16'h0002);
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, irq}, 16'h0000);
        chk({por_cnt, man_cnt}, 16'h0101);
    endtask

    task automatic summarize;
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence after four reset cycles.
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_select;
        t_interval;
        t_watchdog;
        summarize;
    end

    // The whole run needs under 1000 cycles; far beyond that means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize;
    end
endmodule

bind watchdog_interval_timer watchdog_interval_timer_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (.ref_clk(ref_clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .interval_interrupt_request(interval_interrupt_request), .watchdog_overflow_output(watchdog_overflow_output),
    .por_request(por_request), .manual_reset_request(manual_reset_request), .irq(irq));
